// ===== rtl/pus_pkg.sv
// Shared constants and types for the unit index and event status registers
package pus_pkg;

	localparam logic [11:0] PUS_SEL_OFS = 12'h520;
	localparam logic [11:0] PUS_RES_OFS = 12'h524;
	localparam logic [11:0] PUS_INT_OFS = 12'h528;
	localparam logic [11:0] PUS_WIN_LO = 12'h52c;
	localparam logic [11:0] PUS_WIN_HI = 12'h5b3;

	localparam int PUS_FIRE_MAX = 3;
	localparam int PUS_CAP_MAX = 2;

	localparam int PUS_FIRE_POS = 0;
	localparam int PUS_CAP_POS = 8;
	localparam int PUS_PIN_POS = 16;
	localparam int PUS_ERR_POS = 16;
	localparam int PUS_DONE_POS = 0;
	localparam int PUS_FINT_POS = 16;
	localparam int PUS_CINT_POS = 0;

	localparam logic [1:0] PUS_FIRE_RESERVED = 2'h3;
	localparam logic [9:0] PUS_SEL_RST = 10'h000;
	localparam logic [2:0] PUS_FLAG3_RST = 3'h0;
	localparam logic [1:0] PUS_FLAG2_RST = 2'h0;

	// Index register image, msb first: bits 19:16, 11:8, 1:0
	typedef struct packed {
		logic [2:0] spare_hi;
		logic pin;
		logic [2:0] spare_mid;
		logic cap;
		logic [1:0] fire;
	} pus_sel_t;

	// Forwarded access into the indexed window
	typedef struct packed {
		logic req;
		logic write;
		logic [11:0] addr;
		logic [31:0] wdata;
		logic pin;
		logic cap;
		logic [1:0] fire;
	} pus_win_t;

	// Bus transfer state
	typedef enum logic [3:0] {
		PUS_IDLE = 4'b0001,
		PUS_RDWAIT = 4'b0010,
		PUS_WINREQ = 4'b0100,
		PUS_WINWAIT = 4'b1000
	} pus_state_t;

endpackage

// ===== rtl/pus_flag_cell.sv
// Sticky event flags with write-one clear; a set beats a clear
`timescale 1ns/1ps
`default_nettype none
module pus_flag_cell #(
	parameter int W = 3
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [W-1:0] set,
	input wire logic [W-1:0] clr,
	output logic [W-1:0] flag
);

	generate
		if (W < 1 || W > 3) begin : g_bad_width
			$error("pus_flag_cell width must be 1 to 3");
		end
	endgenerate

	typedef struct packed {
		logic [W-1:0] flag_r;
	} pus_cell_t;

	pus_cell_t st_r;
	pus_cell_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		// Clearing first lets an event in the same cycle survive
		st_nxt.flag_r = (st_r.flag_r & ~clr) | set;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign flag = st_r.flag_r;

endmodule
`default_nettype wire

// ===== rtl/pus_top.sv
// Unit index register, trigger result and unit interrupt flags on AHB-Lite
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Window accesses go to the selected units
// - Bit 16 picks second or first pin
// - Bit 8 picks capture unit one or zero
// - Bits 1:0 pick fire unit; 11 reserved
// - Late target with notify sets error flag
// - Error clears on enable-off or write-one
// - Done flag set on fire with notify, write-one clears
// - Per fire unit interrupt flags, write clears
// - Per capture unit interrupt flags, write clears
// - Global GPIO interrupt is OR of flags
// - Egress timestamp interrupts stay elsewhere
module pus_top
	import pus_pkg::*;
#(
	parameter int FIRE_N = 3,
	parameter int CAP_N = 2
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [FIRE_N-1:0] fire_notify_enable,
	input wire logic [FIRE_N-1:0] fire_late_evt,
	input wire logic [FIRE_N-1:0] fire_done_evt,
	input wire logic [FIRE_N-1:0] fire_enable_off,
	input wire logic [CAP_N-1:0] capture_int_enable,
	input wire logic [CAP_N-1:0] capture_evt,
	input wire logic [31:0] win_rdata,
	output pus_win_t win,
	output logic pin_selector,
	output logic capture_unit_selector,
	output logic [1:0] fire_unit_selector,
	output logic gpio_event_int
);

	generate
		if (FIRE_N < 1 || FIRE_N > PUS_FIRE_MAX ||
			CAP_N < 1 || CAP_N > PUS_CAP_MAX) begin : g_bad_count
			$error("pus_top unit counts exceed the register layout");
		end
	endgenerate

	typedef struct packed {
		pus_state_t fsm;
		logic pw_valid;
		logic [11:0] pw_addr;
		logic [11:0] rd_addr;
		pus_sel_t sel;
		logic [31:0] rdata;
		logic ready;
		logic resp;
		pus_win_t win;
		logic irq;
	} pus_state_reg_t;

	pus_state_reg_t st_r;
	pus_state_reg_t st_nxt;

	logic [2:0] err_flag;
	logic [2:0] done_flag;
	logic [2:0] fint_flag;
	logic [1:0] cint_flag;
	logic [2:0] err_set;
	logic [2:0] done_set;
	logic [2:0] fint_set;
	logic [1:0] cint_set;
	logic [2:0] err_clr;
	logic [2:0] done_clr;
	logic [2:0] fint_clr;
	logic [1:0] cint_clr;
	logic [2:0] notify3;
	logic [2:0] late3;
	logic [2:0] fired3;
	logic [2:0] off3;
	logic [1:0] cap_en2;
	logic [1:0] cap_evt2;
	logic addr_take;
	logic [11:0] a_ofs;
	logic a_win;
	logic wr_apply;
	logic wr_sel;
	logic wr_res;
	logic wr_int;
	logic [31:0] res_word;
	logic [31:0] int_word;
	logic [31:0] sel_word;
	logic [31:0] reg_word;

	// Missing units simply never raise events
	always_comb begin
		notify3 = '0;
		late3 = '0;
		fired3 = '0;
		off3 = '0;
		cap_en2 = '0;
		cap_evt2 = '0;
		notify3[FIRE_N-1:0] = fire_notify_enable;
		late3[FIRE_N-1:0] = fire_late_evt;
		fired3[FIRE_N-1:0] = fire_done_evt;
		off3[FIRE_N-1:0] = fire_enable_off;
		cap_en2[CAP_N-1:0] = capture_int_enable;
		cap_evt2[CAP_N-1:0] = capture_evt;
	end

	assign addr_take = hsel && htrans[1] && hready;
	assign a_ofs = haddr[11:0];
	assign a_win = (a_ofs >= PUS_WIN_LO) && (a_ofs <= PUS_WIN_HI);

	// A write lands at the edge that ends its data phase
	assign wr_apply = st_r.pw_valid && (st_r.fsm == PUS_IDLE);
	assign wr_sel = wr_apply && (st_r.pw_addr == PUS_SEL_OFS);
	assign wr_res = wr_apply && (st_r.pw_addr == PUS_RES_OFS);
	assign wr_int = wr_apply && (st_r.pw_addr == PUS_INT_OFS);

	// Events only count while the unit's notify or enable is on
	assign err_set = late3 & notify3;
	assign done_set = fired3 & notify3;
	assign fint_set = (err_set | done_set);
	assign cint_set = cap_evt2 & cap_en2;

	always_comb begin
		err_clr = off3;
		done_clr = '0;
		fint_clr = '0;
		cint_clr = '0;
		if (wr_res) begin
			err_clr = off3 | hwdata[PUS_ERR_POS +: 3];
			done_clr = hwdata[PUS_DONE_POS +: 3];
		end
		if (wr_int) begin
			fint_clr = hwdata[PUS_FINT_POS +: 3];
			cint_clr = hwdata[PUS_CINT_POS +: 2];
		end
	end

	pus_flag_cell #(
		.W(3)
	) u_err (
		.hclk(hclk),
		.hresetn(hresetn),
		.set(err_set),
		.clr(err_clr),
		.flag(err_flag)
	);

	pus_flag_cell #(
		.W(3)
	) u_done (
		.hclk(hclk),
		.hresetn(hresetn),
		.set(done_set),
		.clr(done_clr),
		.flag(done_flag)
	);

	pus_flag_cell #(
		.W(3)
	) u_fint (
		.hclk(hclk),
		.hresetn(hresetn),
		.set(fint_set),
		.clr(fint_clr),
		.flag(fint_flag)
	);

	pus_flag_cell #(
		.W(2)
	) u_cint (
		.hclk(hclk),
		.hresetn(hresetn),
		.set(cint_set),
		.clr(cint_clr),
		.flag(cint_flag)
	);

	always_comb begin
		sel_word = '0;
		sel_word[PUS_FIRE_POS +: 2] = st_r.sel.fire;
		sel_word[PUS_CAP_POS] = st_r.sel.cap;
		sel_word[PUS_CAP_POS+1 +: 3] = st_r.sel.spare_mid;
		sel_word[PUS_PIN_POS] = st_r.sel.pin;
		sel_word[PUS_PIN_POS+1 +: 3] = st_r.sel.spare_hi;
		res_word = '0;
		res_word[PUS_ERR_POS +: 3] = err_flag;
		res_word[PUS_DONE_POS +: 3] = done_flag;
		int_word = '0;
		int_word[PUS_FINT_POS +: 3] = fint_flag;
		int_word[PUS_CINT_POS +: 2] = cint_flag;
		case (st_r.rd_addr)
			PUS_SEL_OFS: reg_word = sel_word;
			PUS_RES_OFS: reg_word = res_word;
			PUS_INT_OFS: reg_word = int_word;
			default: reg_word = '0;
		endcase
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.win.req = 1'b0;
		st_nxt.resp = 1'b0;
		// Port egress timestamp events are not merged here
		st_nxt.irq = |int_word;
		if (wr_sel) begin
			// Reserved code 11 is stored as written; software avoids it
			st_nxt.sel.fire = hwdata[PUS_FIRE_POS +: 2];
			st_nxt.sel.cap = hwdata[PUS_CAP_POS];
			st_nxt.sel.spare_mid = hwdata[PUS_CAP_POS+1 +: 3];
			st_nxt.sel.pin = hwdata[PUS_PIN_POS];
			st_nxt.sel.spare_hi = hwdata[PUS_PIN_POS+1 +: 3];
		end
		if (wr_apply) begin
			st_nxt.pw_valid = 1'b0;
			if ((st_r.pw_addr >= PUS_WIN_LO) &&
				(st_r.pw_addr <= PUS_WIN_HI)) begin
				// Window write leaves with the selectors in force now
				st_nxt.win.req = 1'b1;
				st_nxt.win.write = 1'b1;
				st_nxt.win.addr = st_r.pw_addr;
				st_nxt.win.wdata = hwdata;
				st_nxt.win.pin = st_r.sel.pin;
				st_nxt.win.cap = st_r.sel.cap;
				st_nxt.win.fire = st_r.sel.fire;
			end
		end
		case (st_r.fsm)
			PUS_IDLE: begin
				if (addr_take) begin
					if (hwrite) begin
						st_nxt.pw_valid = 1'b1;
						st_nxt.pw_addr = {a_ofs[11:2], 2'b00};
					end else begin
						// One wait state for registers, two for the window, so a write just before is seen
						st_nxt.rd_addr = {a_ofs[11:2], 2'b00};
						st_nxt.ready = 1'b0;
						st_nxt.fsm = a_win ? PUS_WINREQ : PUS_RDWAIT;
					end
				end
			end
			PUS_RDWAIT: begin
				st_nxt.rdata = reg_word;
				st_nxt.ready = 1'b1;
				st_nxt.fsm = PUS_IDLE;
			end
			PUS_WINREQ: begin
				st_nxt.win.req = 1'b1;
				st_nxt.win.write = 1'b0;
				st_nxt.win.addr = st_r.rd_addr;
				st_nxt.win.wdata = '0;
				st_nxt.win.pin = st_r.sel.pin;
				st_nxt.win.cap = st_r.sel.cap;
				st_nxt.win.fire = st_r.sel.fire;
				st_nxt.fsm = PUS_WINWAIT;
			end
			PUS_WINWAIT: begin
				// The unit answers within the cycle of its request
				st_nxt.rdata = win_rdata;
				st_nxt.ready = 1'b1;
				st_nxt.fsm = PUS_IDLE;
			end
			default: begin
				st_nxt.fsm = PUS_IDLE;
				st_nxt.ready = 1'b1;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r.fsm <= PUS_IDLE;
			st_r.pw_valid <= 1'b0;
			st_r.pw_addr <= '0;
			st_r.rd_addr <= '0;
			st_r.sel <= PUS_SEL_RST;
			st_r.rdata <= '0;
			st_r.ready <= 1'b1;
			st_r.resp <= 1'b0;
			st_r.win <= '0;
			st_r.irq <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign hreadyout = st_r.ready;
	assign hresp = st_r.resp;
	assign hrdata = st_r.rdata;
	assign win = st_r.win;
	assign pin_selector = st_r.sel.pin;
	assign capture_unit_selector = st_r.sel.cap;
	assign fire_unit_selector = st_r.sel.fire;
	assign gpio_event_int = st_r.irq;

endmodule
`default_nettype wire

// ===== bench/pus_top_properties.sv
// Bus timing and interrupt checks for the unit index block
`timescale 1ns/1ps
`default_nettype none
module pus_top_properties
	import pus_pkg::*;
#(
	parameter int FIRE_N = 3,
	parameter int CAP_N = 2
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire pus_win_t win,
	input wire logic [FIRE_N-1:0] fire_notify_enable,
	input wire logic [FIRE_N-1:0] fire_late_evt,
	input wire logic [FIRE_N-1:0] fire_done_evt,
	input wire logic [CAP_N-1:0] capture_int_enable,
	input wire logic [CAP_N-1:0] capture_evt,
	input wire logic gpio_event_int
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("response not OKAY");
	a_write_nowait: assert property (hsel && htrans[1] && hready && hwrite
		|=> hreadyout) else $error("write stalled");
	a_read_wait: assert property (hsel && htrans[1] && hready && !hwrite
		|=> !hreadyout) else $error("read did not wait");
	a_wait_bound: assert property ($fell(hreadyout) |-> ##[1:2] hreadyout)
		else $error("read wait too long");
	a_win_pulse: assert property (win.req && !win.write |=> !win.req)
		else $error("window read request not a pulse");
	a_win_rd_wait: assert property (win.req && !win.write |-> !hreadyout)
		else $error("window read request outside read wait");
	a_cap_int: assert property (|(capture_evt & capture_int_enable)
		|-> ##2 gpio_event_int) else $error("capture interrupt missing");
	a_late_int: assert property (|(fire_late_evt & fire_notify_enable)
		|-> ##2 gpio_event_int) else $error("late interrupt missing");
	a_done_int: assert property (|(fire_done_evt & fire_notify_enable)
		|-> ##2 gpio_event_int) else $error("done interrupt missing");
endmodule
bind pus_top pus_top_properties #(.FIRE_N(FIRE_N), .CAP_N(CAP_N)) u_props (
	.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
	.win, .fire_notify_enable, .fire_late_evt, .fire_done_evt,
	.capture_int_enable, .capture_evt, .gpio_event_int
);
`default_nettype wire

// ===== bench/pus_top_tb.sv
// Register level bench for the unit index and event status block
`timescale 1ns/1ps
`default_nettype none
module pus_top_tb
	import pus_pkg::*;
;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	logic [1:0] htrans = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, win_rdata = 0;
	logic hready, hreadyout, hresp, pin_selector, capture_unit_selector;
	logic gpio_event_int;
	logic [1:0] fire_unit_selector;
	logic [2:0] fire_notify_enable = 0, fire_late_evt = 0;
	logic [2:0] fire_done_evt = 0, fire_enable_off = 0;
	logic [1:0] capture_int_enable = 0, capture_evt = 0;
	pus_win_t win, wseen;
	int n_fail = 0, cmp_count = 0;
	// One slave, so its ready is the bus ready
	assign hready = hreadyout;
	pus_top u_pus_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready, .hreadyout, .hresp, .hrdata,
		.fire_notify_enable, .fire_late_evt, .fire_done_evt, .fire_enable_off,
		.capture_int_enable, .capture_evt, .win_rdata, .win, .pin_selector,
		.capture_unit_selector, .fire_unit_selector, .gpio_event_int);
	initial forever #2 hclk = ~hclk;
	always @(posedge hclk) if (win.req === 1'b1) wseen <= win;
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
		hsel <= 1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 0;
		hsel <= 0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
	endtask
	task wr(input logic [31:0] a, input logic [31:0] d);
		xfer(a, 1, d);
	endtask
	task rd(input string n, input logic [31:0] a, input logic [31:0] e);
		xfer(a, 0, 32'h0);
		chk(n, e, hrdata);
	endtask
	task results;
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Generous: 5000 cycles against the fewer than two hundred the tests need
	initial begin
		#20000;
		n_fail++;
		results();
	end
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1;
		rd("sel", 32'h520, 0);
		rd("res", 32'h524, 0);
		rd("int", 32'h528, 0);
		for (int i = 0; i < 3; i++) begin
			wr(32'h520, {15'h0, i[0], 7'h0, i[1], 6'h0, i[1:0]});
			@(posedge hclk);
			chk("pin", i[0], pin_selector);
			chk("cap", i[1], capture_unit_selector);
			chk("fire", i[1:0], fire_unit_selector);
		end
		wr(32'h520, 32'hfffffffe);
		rd("selrw", 32'h520, 32'h000f0f02);
		wr(32'h520, 32'h00010102);
		wr(32'h530, 32'h12345678);
		repeat (2) @(posedge hclk);
		chk("wdata", 32'h12345678, wseen.wdata);
		chk("waddr", 32'h530, wseen.addr);
		chk("wsel", 5'h1e, {wseen.write, wseen.pin, wseen.cap, wseen.fire});
		win_rdata <= 32'h0a5a0003;
		rd("win", 32'h52c, 32'h0a5a0003);
		chk("rreq", 32'h0e52c, {wseen.write, wseen.pin, wseen.cap,
			wseen.fire, wseen.addr});
		wr(32'h600, 32'hffffffff);
		rd("unmap", 32'h600, 0);
		fire_notify_enable <= 3'h7;
		capture_int_enable <= 2'h3;
		for (int u = 0; u < 3; u++) begin
			fire_late_evt <= 3'h1 << u;
			@(posedge hclk);
			fire_late_evt <= 0;
			rd("err", 32'h524, 32'h10000 << u);
			rd("fint", 32'h528, 32'h10000 << u);
			chk("gint", 1, gpio_event_int);
			fire_enable_off <= 3'h1 << u;
			@(posedge hclk);
			fire_enable_off <= 0;
			fire_done_evt <= 3'h1 << u;
			@(posedge hclk);
			fire_done_evt <= 0;
			rd("done", 32'h524, 32'h1 << u);
			wr(32'h524, 32'h1 << u);
			wr(32'h528, 32'h70003);
			rd("clr", 32'h524, 0);
		end
		fire_late_evt <= 3'h7;
		@(posedge hclk);
		fire_late_evt <= 0;
		wr(32'h524, 32'h70000);
		rd("w1c", 32'h524, 0);
		wr(32'h528, 32'h70003);
		for (int u = 0; u < 2; u++) begin
			capture_evt <= 2'h1 << u;
			@(posedge hclk);
			capture_evt <= 0;
			rd("cint", 32'h528, 32'h1 << u);
			wr(32'h528, 32'h1 << u);
		end
		fire_notify_enable <= 0;
		capture_int_enable <= 0;
		fire_late_evt <= 3'h7;
		fire_done_evt <= 3'h7;
		capture_evt <= 2'h3;
		@(posedge hclk);
		fire_late_evt <= 0;
		fire_done_evt <= 0;
		capture_evt <= 0;
		rd("gated", 32'h528, 0);
		rd("nores", 32'h524, 0);
		chk("gint0", 0, gpio_event_int);
		// Reset again in mid-run with a selector and a flag set
		wr(32'h520, 32'h00010101);
		capture_int_enable <= 2'h1;
		capture_evt <= 2'h1;
		@(posedge hclk);
		capture_evt <= 0;
		repeat (2) @(posedge hclk);
		chk("pregint", 1, gpio_event_int);
		hresetn <= 0;
		repeat (3) @(posedge hclk);
		hresetn <= 1;
		chk("rstpin", 0, pin_selector);
		chk("rstgint", 0, gpio_event_int);
		rd("rstsel", 32'h520, 0);
		rd("rstint", 32'h528, 0);
		results();
	end
endmodule
`default_nettype wire
